// [core/cantrx_pkg.sv]
package cantrx_pkg;
  // ----------------------------------------
  // transceiver mode encodings
  // ----------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_WAKE = 2'h1;
  localparam logic [1:0] MODE_RXONLY = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h3;
  localparam logic [1:0] MODE_RESET = MODE_OFF;
  // ----------------------------------------
  // system chip modes
  // ----------------------------------------
  localparam logic [2:0] SYS_NORMAL = 3'h0;
  localparam logic [2:0] SYS_STOP = 3'h1;
  localparam logic [2:0] SYS_SLEEP = 3'h2;
  localparam logic [2:0] SYS_RESTART = 3'h3;
  localparam logic [2:0] SYS_FAILSAFE = 3'h4;
  // ----------------------------------------
  // timing defaults in clock cycles, and receive buffer depth and width
  // ----------------------------------------
  localparam int EN_SETTLE_CYC = 20;
  localparam int WAKE_MIN_CYC = 50;
  localparam int WAKE_MAX_CYC = 500;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 1;
endpackage

// [core/cantrx_fifo.sv]
`timescale 1ns/1ps
module cantrx_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      if (do_wr && !do_rd) count <= count + 1'b1;
      else if (do_rd && !do_wr) count <= count - 1'b1;
    end
  end
endmodule // cantrx_fifo

// [core/cantrx_core.sv]
`timescale 1ns/1ps
// Overview of operation
// - start in off mode; off allowed except in system fail-safe; bus driver released in off
// - off mode ignores bus wake activity, no wake indication
// - mode changes follow the host mode bits, fail-safe forcing, or a drop back to off
// - host may select normal mode in system normal mode
// - normal transmit/receive only in system normal or stop
// - after settling, ignore standing dominant, send only a fresh one
// - normal mode drives dominant when transmit input is low
// - operating modes show bus state on receive output
// - receive-only keeps driver off, receive still follows bus
// - receive-only selectable only in system normal or stop
// - wake capable selectable in stop, sleep, restart, normal
// - system fail-safe forces wake capable mode
// - detected wake holds receive low until mode changes
// - wake pattern: dominant, recessive, dominant, each within window
// - mode reads wake capable after a wake until software changes it
// - wake rearmed by leaving and re-entering wake capable
// - wake rearmed on entering system stop or fail-safe
module cantrx_core #(
  parameter int EN_SETTLE = cantrx_pkg::EN_SETTLE_CYC,
  parameter int WAKE_MIN = cantrx_pkg::WAKE_MIN_CYC,
  parameter int WAKE_MAX = cantrx_pkg::WAKE_MAX_CYC,
  parameter int DEPTH = cantrx_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // host configuration
  input wire logic [1:0] mode_req,
  input wire logic [2:0] system_chip_mode,
  output logic [1:0] mode_state,
  output logic wake_flag,
  output logic tx_ready,
  // controller pins
  input wire logic tx_data_in,
  output logic rx_data_out,
  // bus side
  input wire logic bus_dominant_in,
  output logic bus_drive_dom,
  output logic bus_drive_oe,
  // received bit stream
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_bit,
  output logic rx_overflow
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic tx_s1, tx_s2, bus_s1, bus_s2;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_s1 <= 1'b1;
      tx_s2 <= 1'b1;
      bus_s1 <= 1'b0;
      bus_s2 <= 1'b0;
    end else begin
      tx_s1 <= tx_data_in;
      tx_s2 <= tx_s1;
      bus_s1 <= bus_dominant_in;
      bus_s2 <= bus_s1;
    end
  end

  // ----------------------------------------
  // mode selection
  // ----------------------------------------
  logic [1:0] mode;
  logic [2:0] sys_prev;
  wire sys_norm_stop = (system_chip_mode == cantrx_pkg::SYS_NORMAL) ||
                       (system_chip_mode == cantrx_pkg::SYS_STOP);
  wire sys_fs = (system_chip_mode == cantrx_pkg::SYS_FAILSAFE);
  wire wake_ok = sys_norm_stop || (system_chip_mode == cantrx_pkg::SYS_SLEEP) ||
                 (system_chip_mode == cantrx_pkg::SYS_RESTART);
  wire req_ok = (mode_req == cantrx_pkg::MODE_OFF) ||
                (mode_req == cantrx_pkg::MODE_NORMAL && sys_norm_stop) ||
                (mode_req == cantrx_pkg::MODE_RXONLY && sys_norm_stop) ||
                (mode_req == cantrx_pkg::MODE_WAKE && wake_ok);
  // a mode that the system mode no longer allows drops back to off
  wire cur_ok = (mode == cantrx_pkg::MODE_OFF) || (mode == cantrx_pkg::MODE_WAKE) ||
                sys_norm_stop;
  wire [1:0] next_mode = sys_fs ? cantrx_pkg::MODE_WAKE :
                         (mode_req != mode && req_ok) ? mode_req :
                         cur_ok ? mode : cantrx_pkg::MODE_OFF;
  wire mode_change = (next_mode != mode);
  wire sys_rearm = (system_chip_mode != sys_prev) &&
                   (sys_fs || system_chip_mode == cantrx_pkg::SYS_STOP);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode <= cantrx_pkg::MODE_RESET;
      sys_prev <= cantrx_pkg::SYS_RESTART;
    end else begin
      mode <= next_mode;
      sys_prev <= system_chip_mode;
    end
  end
  assign mode_state = mode;

  // ----------------------------------------
  // transmit enable settling
  // ----------------------------------------
  localparam int SW = $clog2(EN_SETTLE + 1);
  logic [SW-1:0] settle_cnt;
  logic tx_armed;
  wire in_normal = (mode == cantrx_pkg::MODE_NORMAL);
  wire settled = (settle_cnt == SW'(EN_SETTLE));
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      settle_cnt <= '0;
      tx_armed <= 1'b0;
    end else if (!in_normal || mode_change) begin
      settle_cnt <= '0;
      tx_armed <= 1'b0;
    end else if (!settled) begin
      settle_cnt <= settle_cnt + 1'b1;
    end else if (tx_s2) begin
      tx_armed <= 1'b1;
    end
  end
  assign tx_ready = in_normal && settled;
  // standing dominant after settling is held back until a recessive is seen
  assign bus_drive_oe = in_normal && settled && tx_armed;
  assign bus_drive_dom = bus_drive_oe && !tx_s2;

  // ----------------------------------------
  // wake pattern detector
  // ----------------------------------------
  typedef enum logic [2:0] {W_IDLE, W_DOM1, W_REC, W_DOM2, W_DONE} cantrx_wst_t;
  cantrx_wst_t wst;
  localparam int WW = $clog2(WAKE_MAX + 1);
  logic [WW-1:0] ph_cnt;
  logic wake_hit, woke;
  wire in_wake = (mode == cantrx_pkg::MODE_WAKE);
  wire ph_long = (ph_cnt >= WW'(WAKE_MAX));
  wire ph_good = (ph_cnt > WW'(WAKE_MIN)) && !ph_long;
  wire rearm = !in_wake || mode_change || sys_rearm;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wst <= W_IDLE;
      ph_cnt <= '0;
    end else if (rearm) begin
      wst <= W_IDLE;
      ph_cnt <= '0;
    end else begin
      if (!ph_long) ph_cnt <= ph_cnt + 1'b1;
      // count starts at 1 so it equals the phase length at the closing edge
      case (wst)
        W_IDLE: begin
          ph_cnt <= WW'(1);
          if (bus_s2) wst <= W_DOM1;
        end
        W_DOM1: begin
          if (!bus_s2) begin
            ph_cnt <= WW'(1);
            wst <= ph_good ? W_REC : W_IDLE;
          end else if (ph_long) begin
            wst <= W_IDLE;
          end
        end
        W_REC: begin
          if (bus_s2) begin
            ph_cnt <= WW'(1);
            wst <= ph_good ? W_DOM2 : W_DOM1;
          end else if (ph_long) begin
            wst <= W_IDLE;
          end
        end
        W_DOM2: begin
          if (!bus_s2) begin
            ph_cnt <= '0;
            wst <= ph_good ? W_DONE : W_IDLE;
          end else if (ph_long) begin
            wst <= W_IDLE;
          end
        end
        W_DONE: ph_cnt <= '0;
        default: wst <= W_IDLE;
      endcase
    end
  end
  assign wake_hit = (wst == W_DOM2) && !rearm && !bus_s2 && ph_good;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      woke <= 1'b0;
    end else if (wake_hit) begin
      woke <= 1'b1;
    end else if (mode_change) begin
      woke <= 1'b0;
    end
  end
  assign wake_flag = woke;

  // ----------------------------------------
  // receive path
  // ----------------------------------------
  wire operating = (mode == cantrx_pkg::MODE_NORMAL) || (mode == cantrx_pkg::MODE_RXONLY);
  logic rx_q;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_q <= 1'b1;
    end else begin
      rx_q <= woke ? 1'b0 : operating ? !bus_s2 : 1'b1;
    end
  end
  assign rx_data_out = rx_q;

  // sampled bit stream buffered for a slower consumer; drops show as overflow
  logic fifo_in_ready, ovf;
  cantrx_fifo #(.WIDTH(cantrx_pkg::FIFO_WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(operating),
    .in_ready(fifo_in_ready),
    .in_data(!bus_s2),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_bit)
  );
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) ovf <= 1'b0;
    else if (operating && !fifo_in_ready) ovf <= 1'b1;
    else if (!operating) ovf <= 1'b0;
  end
  assign rx_overflow = ovf;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // separate count of cycles spent in normal mode, for the settling check
  logic [SW-1:0] norm_age;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      norm_age <= '0;
    end else if (!in_normal) begin
      norm_age <= '0;
    end else if (norm_age != SW'(EN_SETTLE)) begin
      norm_age <= norm_age + 1'b1;
    end
  end
  property p_off_quiet;
    @(posedge clk_sys) disable iff (reset)
    (mode == cantrx_pkg::MODE_OFF) |-> !bus_drive_oe && !wake_flag;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("off mode active");
  property p_rxonly_nodrive;
    @(posedge clk_sys) disable iff (reset)
    (mode == cantrx_pkg::MODE_RXONLY) |-> !bus_drive_dom;
  endproperty
  a_rxonly_nodrive: assert property (p_rxonly_nodrive) else $error("rx-only drives");
  property p_failsafe_wake;
    @(posedge clk_sys) disable iff (reset)
    sys_fs |=> (mode == cantrx_pkg::MODE_WAKE);
  endproperty
  a_failsafe_wake: assert property (p_failsafe_wake) else $error("fail-safe no wake");
  property p_oper_sys;
    @(posedge clk_sys) disable iff (reset)
    $changed(mode) && operating |-> $past(sys_norm_stop);
  endproperty
  a_oper_sys: assert property (p_oper_sys) else $error("bad system mode");
  property p_settle;
    @(posedge clk_sys) disable iff (reset)
    bus_drive_oe |-> (norm_age == SW'(EN_SETTLE));
  endproperty
  a_settle: assert property (p_settle) else $error("driver before settling");
  property p_follow;
    @(posedge clk_sys) disable iff (reset)
    bus_drive_oe |-> (bus_drive_dom == !$past(tx_data_in, 2));
  endproperty
  a_follow: assert property (p_follow) else $error("tx not followed");
  sequence s_woke;
    $rose(woke);
  endsequence
  property p_wake_rx;
    @(posedge clk_sys) disable iff (reset)
    s_woke |=> !rx_data_out && (mode == cantrx_pkg::MODE_WAKE);
  endproperty
  a_wake_rx: assert property (p_wake_rx) else $error("wake not on rx");
  property p_rx_bus;
    @(posedge clk_sys) disable iff (reset)
    operating && !woke |=> (rx_data_out == !$past(bus_s2));
  endproperty
  a_rx_bus: assert property (p_rx_bus) else $error("rx not bus");
  property p_fresh_dom;
    @(posedge clk_sys) disable iff (reset)
    $rose(bus_drive_oe) |-> $past(tx_data_in, 3);
  endproperty
  a_fresh_dom: assert property (p_fresh_dom) else $error("driver armed on dominant");
  property p_rxonly_oe;
    @(posedge clk_sys) disable iff (reset)
    (mode == cantrx_pkg::MODE_RXONLY) |-> !bus_drive_oe;
  endproperty
  a_rxonly_oe: assert property (p_rxonly_oe) else $error("rx-only enables driver");
  property p_idle_rx;
    @(posedge clk_sys) disable iff (reset)
    !operating && !woke |=> rx_data_out;
  endproperty
  a_idle_rx: assert property (p_idle_rx) else $error("rx low while idle");
  property p_wake_hold;
    @(posedge clk_sys) disable iff (reset)
    woke && !mode_change |=> woke;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake lost early");
  property p_wake_clear;
    @(posedge clk_sys) disable iff (reset)
    mode_change |=> !woke;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake kept over mode change");
  property p_mode_src;
    @(posedge clk_sys) disable iff (reset)
    $changed(mode) |-> (mode == $past(mode_req)) || $past(sys_fs) ||
                       (mode == cantrx_pkg::MODE_OFF);
  endproperty
  a_mode_src: assert property (p_mode_src) else $error("mode not from host bits");
  property p_wake_sel;
    @(posedge clk_sys) disable iff (reset)
    $changed(mode) && (mode == cantrx_pkg::MODE_WAKE) |-> $past(wake_ok) || $past(sys_fs);
  endproperty
  a_wake_sel: assert property (p_wake_sel) else $error("wake mode in bad system mode");
  sequence s_dom_then_rec;
    $past(bus_s2, 2) && !$past(bus_s2);
  endsequence
  property p_wake_edge;
    @(posedge clk_sys) disable iff (reset)
    s_woke |-> s_dom_then_rec;
  endproperty
  a_wake_edge: assert property (p_wake_edge) else $error("wake without closing edge");
  property p_wake_mode;
    @(posedge clk_sys) disable iff (reset)
    s_woke |-> $past(in_wake);
  endproperty
  a_wake_mode: assert property (p_wake_mode) else $error("wake outside wake mode");
  property p_rearm_sys;
    @(posedge clk_sys) disable iff (reset)
    sys_rearm |=> (wst == W_IDLE);
  endproperty
  a_rearm_sys: assert property (p_rearm_sys) else $error("no rearm on system entry");
endmodule // cantrx_core

// [dv/cantrx_bus_model.sv]
`timescale 1ns/1ps
module cantrx_bus_model (
  // clock
  input wire logic clk_sys,
  // controller side
  input wire logic tx_req,
  input wire logic tx_early,
  input wire logic tx_ready,
  output logic tx_data_in,
  // bus side
  input wire logic remote_dom,
  input wire logic bus_drive_dom,
  input wire logic bus_drive_oe,
  output logic bus_dominant_in
);
  // ----------------------------------------
  // controller pin
  // ----------------------------------------
  // early forces a dominant before settling, for the standing-dominant case
  initial tx_data_in = 1'b1;
  always @(posedge clk_sys) begin
    tx_data_in <= !(tx_req && (tx_ready || tx_early));
  end
  // ----------------------------------------
  // wired bus
  // ----------------------------------------
  // bus is biased recessive once every driver lets go
  assign bus_dominant_in = remote_dom || (bus_drive_oe && bus_drive_dom);
endmodule // cantrx_bus_model

// [dv/test_can_transceiver_mode_wake.sv]
`timescale 1ns/1ps
module test_can_transceiver_mode_wake;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [1:0] mode_req = 2'h0;
  logic [2:0] system_chip_mode = 3'h0;
  logic rx_ready = 1'b0;
  logic tx_req = 1'b0;
  logic tx_early = 1'b0;
  logic remote_dom = 1'b0;
  logic [1:0] mode_state;
  logic wake_flag, tx_ready, tx_data_in, rx_data_out, bus_dominant_in;
  logic bus_drive_dom, bus_drive_oe, rx_valid, rx_bit, rx_overflow;
  logic [2:0] sys_tab [4];
  int n_errors = 0;
  int compares = 0;
  int n;
  // ----------------------------------------
  // clock and instances
  // ----------------------------------------
  initial forever #5 clk_sys = ~clk_sys;
  // short counts keep the run brief
  cantrx_core #(.EN_SETTLE(4), .WAKE_MIN(8), .WAKE_MAX(40), .DEPTH(16)) u_dut (
    .clk_sys(clk_sys), .reset(reset), .mode_req(mode_req),
    .system_chip_mode(system_chip_mode), .mode_state(mode_state), .wake_flag(wake_flag),
    .tx_ready(tx_ready), .tx_data_in(tx_data_in), .rx_data_out(rx_data_out),
    .bus_dominant_in(bus_dominant_in), .bus_drive_dom(bus_drive_dom),
    .bus_drive_oe(bus_drive_oe), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_bit(rx_bit), .rx_overflow(rx_overflow));
  cantrx_bus_model u_bus (
    .clk_sys(clk_sys), .tx_req(tx_req), .tx_early(tx_early), .tx_ready(tx_ready),
    .tx_data_in(tx_data_in), .remote_dom(remote_dom), .bus_drive_dom(bus_drive_dom),
    .bus_drive_oe(bus_drive_oe), .bus_dominant_in(bus_dominant_in));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  task automatic set_mode(input logic [2:0] s, input logic [1:0] m);
    @(posedge clk_sys);
    system_chip_mode <= s;
    mode_req <= m;
    tick(3);
  endtask
  task automatic phase(input logic lvl, input int c);
    @(posedge clk_sys);
    remote_dom <= lvl;
    repeat (c - 1) @(posedge clk_sys);
  endtask
  task automatic wake_pat(input int d1, input int r1, input int d2);
    phase(1'b1, d1);
    phase(1'b0, r1);
    phase(1'b1, d2);
    phase(1'b0, 1);
    tick(6);
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    give_verdict();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    sys_tab = '{cantrx_pkg::SYS_STOP, cantrx_pkg::SYS_SLEEP, cantrx_pkg::SYS_RESTART,
                cantrx_pkg::SYS_NORMAL};
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    tick(2);
    chk("mode_state", cantrx_pkg::MODE_OFF, mode_state);
    chk("bus_drive_oe", 0, bus_drive_oe);
    wake_pat(20, 20, 20);
    chk("wake_flag", 0, wake_flag);
    chk("rx_data_out", 1, rx_data_out);
    // dominant already standing when settling ends must not reach the bus
    @(posedge clk_sys);
    tx_req <= 1'b1;
    tx_early <= 1'b1;
    set_mode(cantrx_pkg::SYS_NORMAL, cantrx_pkg::MODE_NORMAL);
    chk("mode_state", cantrx_pkg::MODE_NORMAL, mode_state);
    tick(20);
    chk("tx_ready", 1, tx_ready);
    chk("bus_dominant_in", 0, bus_dominant_in);
    @(posedge clk_sys);
    tx_req <= 1'b0;
    tx_early <= 1'b0;
    tick(6);
    @(posedge clk_sys);
    tx_req <= 1'b1;
    tick(10);
    chk("bus_drive_oe", 1, bus_drive_oe);
    chk("bus_dominant_in", 1, bus_dominant_in);
    chk("rx_data_out", 0, rx_data_out);
    @(posedge clk_sys);
    tx_req <= 1'b0;
    tick(10);
    chk("bus_dominant_in", 0, bus_dominant_in);
    chk("rx_data_out", 1, rx_data_out);
    set_mode(cantrx_pkg::SYS_SLEEP, cantrx_pkg::MODE_NORMAL);
    chk("mode_state", cantrx_pkg::MODE_OFF, mode_state);
    set_mode(cantrx_pkg::SYS_SLEEP, cantrx_pkg::MODE_RXONLY);
    chk("mode_state", cantrx_pkg::MODE_OFF, mode_state);
    // receive-only with the reader stalled until the buffer refuses
    @(posedge clk_sys);
    tx_req <= 1'b1;
    tx_early <= 1'b1;
    set_mode(cantrx_pkg::SYS_STOP, cantrx_pkg::MODE_RXONLY);
    chk("mode_state", cantrx_pkg::MODE_RXONLY, mode_state);
    @(posedge clk_sys);
    remote_dom <= 1'b1;
    tick(30);
    chk("bus_drive_oe", 0, bus_drive_oe);
    chk("rx_data_out", 0, rx_data_out);
    chk("rx_overflow", 1, rx_overflow);
    chk("rx_bit", 1, rx_bit);
    set_mode(cantrx_pkg::SYS_STOP, cantrx_pkg::MODE_OFF);
    chk("rx_overflow", 0, rx_overflow);
    @(posedge clk_sys);
    remote_dom <= 1'b0;
    tx_req <= 1'b0;
    tx_early <= 1'b0;
    rx_ready <= 1'b1;
    n = 0;
    while (rx_valid === 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk("rx_valid", 0, rx_valid);
    chk("rx_drained", 16, n);
    for (int i = 0; i < 4; i++) begin
      set_mode(sys_tab[i], cantrx_pkg::MODE_WAKE);
      chk("mode_state", cantrx_pkg::MODE_WAKE, mode_state);
      set_mode(sys_tab[i], cantrx_pkg::MODE_OFF);
    end
    set_mode(cantrx_pkg::SYS_FAILSAFE, cantrx_pkg::MODE_OFF);
    chk("mode_state", cantrx_pkg::MODE_WAKE, mode_state);
    set_mode(cantrx_pkg::SYS_NORMAL, cantrx_pkg::MODE_WAKE);
    wake_pat(4, 20, 20);
    chk("wake_flag", 0, wake_flag);
    tick(60);
    // overlong recessive gap must restart the count at the next dominant
    wake_pat(20, 60, 20);
    chk("wake_flag", 0, wake_flag);
    wake_pat(20, 20, 20);
    chk("wake_flag", 1, wake_flag);
    chk("rx_data_out", 0, rx_data_out);
    chk("mode_state", cantrx_pkg::MODE_WAKE, mode_state);
    tick(50);
    chk("rx_data_out", 0, rx_data_out);
    set_mode(cantrx_pkg::SYS_NORMAL, cantrx_pkg::MODE_OFF);
    chk("rx_data_out", 1, rx_data_out);
    chk("wake_flag", 0, wake_flag);
    set_mode(cantrx_pkg::SYS_NORMAL, cantrx_pkg::MODE_WAKE);
    wake_pat(20, 20, 20);
    chk("wake_flag", 1, wake_flag);
    set_mode(cantrx_pkg::SYS_NORMAL, cantrx_pkg::MODE_OFF);
    set_mode(cantrx_pkg::SYS_NORMAL, cantrx_pkg::MODE_WAKE);
    phase(1'b1, 20);
    phase(1'b0, 20);
    // entering stop mid-pattern must drop the half-seen pattern
    set_mode(cantrx_pkg::SYS_STOP, cantrx_pkg::MODE_WAKE);
    phase(1'b1, 20);
    phase(1'b0, 1);
    tick(6);
    chk("wake_flag", 0, wake_flag);
    wake_pat(20, 20, 20);
    chk("wake_flag", 1, wake_flag);
    give_verdict();
  end
endmodule // test_can_transceiver_mode_wake
